/* dpa_alu.sv */
/*
  Execute-stage datapath of a small 32-bit core, reached as an APB slave.
  Assumes an APB3 master on pclk; operands are loaded into registers and a
  write to the control register executes one operation at that access edge.
*/
// Local design decisions: the APB register port and the address map.
// Notes on behaviour
// - AND, OR, XOR of both operands to result.
// - Bit clear: first AND NOT second.
// - Logic ops set N, Z; keep C, V.
// - Shift count from immediate or low byte.
// - Immediate counts: ASR 1-32, LSL 0-31, LSR 1-32.
// - Shifts set N, Z; C last out; V kept.
// - Register flag copy equals LSL by zero.
// - Compare subtracts register or 8-bit immediate, discards.
// - Compare negative adds, discards sum.
// - Compares update N, Z, C, V.
// - Plain copy writes second operand, no flags.
// - Flag copy takes 0-255 immediate, sets N, Z.
// - Invert copy writes inverse of second operand.
// - Copy to program counter clears bit 0, branches.
// - Multiply keeps low 32 bits, sets N, Z.
// - Word byte swap reverses all four bytes.
// - Halves swap bytes within each halfword.
// - Low halfword byte swap, then sign extend.
// - Byte extend from bits 7:0, sign or zero.
// - Half extend from bits 15:0; no flag change.
// - Bit test And_flags_op, sets N, Z, discards.
`include "dpa_consts.svh"

module dpa_alu (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [3:0]  flags_nzcv,
  output logic             branch_valid,
  output logic      [31:0] branch_target
);

  // ****************************************************************
  // Address decoding
  // ****************************************************************

  function automatic dpa_pkg::dpa_sel_t decode_addr(input logic [7:0] addr);
    dpa_pkg::dpa_sel_t sel;
    sel = dpa_pkg::sel_none;
    if (addr == `DPA_OFF_OPA) begin
      sel = dpa_pkg::sel_opa;
    end else if (addr == `DPA_OFF_OPB) begin
      sel = dpa_pkg::sel_opb;
    end else if (addr == `DPA_OFF_SHAMT) begin
      sel = dpa_pkg::sel_shamt;
    end else if (addr == `DPA_OFF_CTRL) begin
      sel = dpa_pkg::sel_ctrl;
    end else if (addr == `DPA_OFF_RESULT) begin
      sel = dpa_pkg::sel_result;
    end else if (addr == `DPA_OFF_FLAGS) begin
      sel = dpa_pkg::sel_flags;
    end else if (addr == `DPA_OFF_TARGET) begin
      sel = dpa_pkg::sel_target;
    end else if (addr == `DPA_OFF_STATUS) begin
      sel = dpa_pkg::sel_status;
    end
    return sel;
  endfunction

  // ****************************************************************
  // Shifter functions, each returning {carry, value}
  // ****************************************************************

  // Counts of zero leave value and carry alone; counts past 31 saturate, but rotate takes them modulo 32.
  function automatic logic [32:0] shift_lsl(input logic [31:0] b, input logic [7:0] n, input logic cin);
    logic [32:0] tmp;
    tmp = {1'b0, b} << n[4:0];
    if (n == 8'h00) begin
      tmp = {cin, b};
    end else if (n == 8'h20) begin
      tmp = {b[0], 32'h0000_0000};
    end else if (n > 8'h20) begin
      tmp = 33'h0_0000_0000;
    end
    return tmp;
  endfunction

  function automatic logic [32:0] shift_lsr(input logic [31:0] b, input logic [7:0] n, input logic cin);
    logic [32:0] tmp;
    logic [32:0] res;
    tmp = {b, 1'b0} >> n[4:0];
    res = {tmp[0], tmp[32:1]};
    if (n == 8'h00) begin
      res = {cin, b};
    end else if (n == 8'h20) begin
      res = {b[31], 32'h0000_0000};
    end else if (n > 8'h20) begin
      res = 33'h0_0000_0000;
    end
    return res;
  endfunction

  function automatic logic [32:0] shift_asr(input logic [31:0] b, input logic [7:0] n, input logic cin);
    logic [32:0] tmp;
    logic [32:0] res;
    tmp = 33'($signed({b, 1'b0}) >>> n[4:0]);
    res = {tmp[0], tmp[32:1]};
    if (n == 8'h00) begin
      res = {cin, b};
    end else if (n >= 8'h20) begin
      res = {b[31], {32{b[31]}}};
    end
    return res;
  endfunction

  function automatic logic [32:0] shift_ror(input logic [31:0] b, input logic [7:0] n, input logic cin);
    logic [31:0] rot;
    logic [32:0] res;
    rot = (b >> n[4:0]) | (b << (6'd32 - {1'b0, n[4:0]}));
    if (n[4:0] == 5'h00) begin
      rot = b;
    end
    res = {rot[31], rot};
    if (n == 8'h00) begin
      res = {cin, b};
    end
    return res;
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************

  logic [31:0] opa;
  logic [31:0] opb;
  logic [31:0] shamt;
  logic [15:0] ctrl;
  logic [31:0] result;
  logic [3:0]  flags;
  logic [31:0] target;
  logic [2:0]  status;

  // ****************************************************************
  // Bus decode
  // ****************************************************************

  dpa_pkg::dpa_sel_t sel;
  wire logic         setup_phase;
  wire logic         access_done;
  wire logic         wr_en;
  wire logic         exec_en;
  wire logic [31:0]  rd_word;

  assign sel         = decode_addr(paddr);
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_en       = access_done & pwrite & (sel != dpa_pkg::sel_none);

  assign rd_word = (sel == dpa_pkg::sel_opa)    ? opa :
                   (sel == dpa_pkg::sel_opb)    ? opb :
                   (sel == dpa_pkg::sel_shamt)  ? shamt :
                   (sel == dpa_pkg::sel_ctrl)   ? {16'h0000, ctrl} :
                   (sel == dpa_pkg::sel_result) ? result :
                   (sel == dpa_pkg::sel_flags)  ? {flags, 28'h000_0000} :
                   (sel == dpa_pkg::sel_target) ? target :
                   (sel == dpa_pkg::sel_status) ? {29'h0000_0000, status} : 32'h0000_0000;

  // ****************************************************************
  // Operation fields taken from the control write
  // ****************************************************************

  dpa_pkg::dpa_op_t op;
  wire logic        imm_sel;
  wire logic        to_pc;
  wire logic [7:0]  imm;
  wire logic [31:0] src2;
  wire logic [7:0]  count;
  wire logic        bad_op;
  wire logic        bad_imm;
  wire logic        reject;

  assign op      = dpa_pkg::dpa_op_t'(pwdata[`DPA_CTRL_OP_MSB:`DPA_CTRL_OP_LSB]);
  assign imm_sel = pwdata[`DPA_CTRL_IMM_SEL];
  assign to_pc   = pwdata[`DPA_CTRL_TO_PC];
  assign imm     = pwdata[`DPA_CTRL_IMM_MSB:`DPA_CTRL_IMM_LSB];
  assign src2    = imm_sel ? {24'h00_0000, imm} : opb;
  assign count   = imm_sel ? imm : shamt[7:0];

  assign bad_op  = pwdata[`DPA_CTRL_OP_MSB:`DPA_CTRL_OP_LSB] > 5'(dpa_pkg::bit_test_op);

  // Immediate forms outside their documented ranges are refused: result, flags and target stay; ctrl and the status reject bit are still written.
  assign bad_imm = imm_sel & (
                   ((op == dpa_pkg::arith_right_shift_op) &
                    ((imm < `DPA_RSH_IMM_MIN) | (imm > `DPA_RSH_IMM_MAX))) |
                   ((op == dpa_pkg::logical_left_shift_op) & (imm > `DPA_LSL_IMM_MAX)) |
                   ((op == dpa_pkg::logical_right_shift_op) &
                    ((imm < `DPA_RSH_IMM_MIN) | (imm > `DPA_RSH_IMM_MAX))) |
                   (op == dpa_pkg::rotate_right_op));
  assign reject  = bad_op | bad_imm;
  assign exec_en = wr_en & (sel == dpa_pkg::sel_ctrl) & ~reject;

  // ****************************************************************
  // Datapath
  // ****************************************************************

  wire logic        cin;
  wire logic        vin;
  wire logic [32:0] lsl_out;
  wire logic [32:0] lsr_out;
  wire logic [32:0] asr_out;
  wire logic [32:0] ror_out;
  wire logic [32:0] sub_out;
  wire logic [32:0] add_out;
  wire logic        sub_v;
  wire logic        add_v;
  wire logic [31:0] prod;
  wire logic [31:0] and_out;

  assign cin     = flags[1];
  assign vin     = flags[0];
  assign lsl_out = shift_lsl(opb, count, cin);
  assign lsr_out = shift_lsr(opb, count, cin);
  assign asr_out = shift_asr(opb, count, cin);
  assign ror_out = shift_ror(opb, count, cin);
  assign sub_out = {1'b0, opa} + {1'b0, ~src2} + 33'h0_0000_0001;
  assign add_out = {1'b0, opa} + {1'b0, opb};
  assign sub_v   = (opa[31] != src2[31]) & (sub_out[31] != opa[31]);
  assign add_v   = (opa[31] == opb[31]) & (add_out[31] != opa[31]);
  assign prod    = opa * opb;
  assign and_out = opa & opb;

  logic [31:0] value;
  logic        next_c;
  logic        next_v;
  logic        writes_result;
  logic        sets_nz;

  always_comb begin
    value         = 32'h0000_0000;
    next_c        = cin;
    next_v        = vin;
    writes_result = 1'b1;
    sets_nz       = 1'b1;
    case (op)
      dpa_pkg::and_flags_op:   value = and_out;
      dpa_pkg::or_flags_op:    value = opa | opb;
      dpa_pkg::xor_flags_op:   value = opa ^ opb;
      dpa_pkg::bit_clear_op:   value = opa & ~opb;
      dpa_pkg::arith_right_shift_op: begin
        {next_c, value} = asr_out;
      end
      dpa_pkg::logical_left_shift_op, dpa_pkg::copy_flags_op: begin
        // A register flag copy is a left shift by zero; an immediate
        // copy goes the same path with a zero count, so carry is kept.
        if (op == dpa_pkg::copy_flags_op) begin
          {next_c, value} = shift_lsl(src2, 8'h00, cin);
        end else begin
          {next_c, value} = lsl_out;
        end
      end
      dpa_pkg::logical_right_shift_op: begin
        {next_c, value} = lsr_out;
      end
      dpa_pkg::rotate_right_op: begin
        {next_c, value} = ror_out;
      end
      dpa_pkg::compare_op: begin
        value         = sub_out[31:0];
        next_c        = sub_out[32];
        next_v        = sub_v;
        writes_result = 1'b0;
      end
      dpa_pkg::compare_negative_op: begin
        value         = add_out[31:0];
        next_c        = add_out[32];
        next_v        = add_v;
        writes_result = 1'b0;
      end
      dpa_pkg::copy_op: begin
        value   = opb;
        sets_nz = 1'b0;
      end
      dpa_pkg::invert_copy_op: value = ~opb;
      dpa_pkg::multiply_op:    value = prod;
      dpa_pkg::byte_swap_word_op: begin
        value   = {opb[7:0], opb[15:8], opb[23:16], opb[31:24]};
        sets_nz = 1'b0;
      end
      dpa_pkg::byte_swap_halves_op: begin
        value   = {opb[23:16], opb[31:24], opb[7:0], opb[15:8]};
        sets_nz = 1'b0;
      end
      dpa_pkg::swap_signext_half_op: begin
        value   = {{16{opb[7]}}, opb[7:0], opb[15:8]};
        sets_nz = 1'b0;
      end
      dpa_pkg::sign_extend_byte_op: begin
        value   = {{24{opb[7]}}, opb[7:0]};
        sets_nz = 1'b0;
      end
      dpa_pkg::zero_extend_byte_op: begin
        value   = {24'h00_0000, opb[7:0]};
        sets_nz = 1'b0;
      end
      dpa_pkg::sign_extend_half_op: begin
        value   = {{16{opb[15]}}, opb[15:0]};
        sets_nz = 1'b0;
      end
      dpa_pkg::zero_extend_half_op: begin
        value   = {16'h0000, opb[15:0]};
        sets_nz = 1'b0;
      end
      dpa_pkg::bit_test_op: begin
        value         = and_out;
        writes_result = 1'b0;
      end
      default: begin
        writes_result = 1'b0;
        sets_nz       = 1'b0;
      end
    endcase
  end

  wire logic        is_branch;
  wire logic        next_n;
  wire logic        next_z;
  wire logic [3:0]  next_flags;

  assign is_branch  = (op == dpa_pkg::copy_op) & to_pc;
  assign next_n     = sets_nz ? value[31] : flags[3];
  assign next_z     = sets_nz ? (value == 32'h0000_0000) : flags[2];
  assign next_flags = {next_n, next_z, next_c, next_v};

  // ****************************************************************
  // APB answer: zero wait states, every output from a flip-flop
  // ****************************************************************

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= `DPA_RST_WORD;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & (sel == dpa_pkg::sel_none);
      prdata  <= (setup_phase & ~pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Operand and control registers
  // ****************************************************************

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opa   <= `DPA_RST_WORD;
      opb   <= `DPA_RST_WORD;
      shamt <= `DPA_RST_WORD;
      ctrl  <= 16'h0000;
    end else if (wr_en) begin
      if (sel == dpa_pkg::sel_opa) begin
        opa <= pwdata;
      end
      if (sel == dpa_pkg::sel_opb) begin
        opb <= pwdata;
      end
      if (sel == dpa_pkg::sel_shamt) begin
        shamt <= pwdata;
      end
      if (sel == dpa_pkg::sel_ctrl) begin
        ctrl <= pwdata[15:0];
      end
    end
  end

  // ****************************************************************
  // Result, flags, branch and status
  // ****************************************************************

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= `DPA_RST_WORD;
      flags  <= `DPA_RST_FLAGS;
      target <= `DPA_RST_WORD;
      status <= 3'h0;
    end else if (wr_en && sel == dpa_pkg::sel_flags) begin
      flags <= pwdata[`DPA_FLAG_N:`DPA_FLAG_V];
    end else if (wr_en && sel == dpa_pkg::sel_ctrl) begin
      status <= {reject, exec_en & is_branch, exec_en & writes_result & ~is_branch};
      if (exec_en) begin
        flags <= next_flags;
        if (is_branch) begin
          target <= {opb[31:1], 1'b0};
        end else if (writes_result) begin
          result <= value;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_nzcv    <= `DPA_RST_FLAGS;
      branch_valid  <= 1'b0;
      branch_target <= `DPA_RST_WORD;
    end else begin
      flags_nzcv    <= exec_en ? next_flags : flags;
      branch_valid  <= exec_en & is_branch;
      branch_target <= (exec_en & is_branch) ? {opb[31:1], 1'b0} : branch_target;
    end
  end

endmodule

/* dpa_alu_chk.sv */
/*
  Concurrent checks on the ports of the data processing ALU, bound to it.
  Assumes zero-wait APB answers and flags shown one cycle after an execute.
*/
module dpa_alu_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  flags_nzcv,
  input wire logic        branch_valid,
  input wire logic [31:0] branch_target
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Shadow operands
  // ********
  logic [31:0] opa_q;
  logic [31:0] opb_q;
  wire         acc = psel & penable & pready & pwrite;
  wire  [4:0]  op = pwdata[4:0];
  wire         ctl = acc && paddr == 8'h0C && op <= 5'd21 && !pwdata[5];
  wire         br_req = ctl && op == 5'd10 && pwdata[6];
  wire  [31:0] dif = opa_q - opb_q;
  wire  [32:0] sum = {1'b0, opa_q} + opb_q;
  wire  [31:0] anv = opa_q & opb_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opa_q <= 32'h0;
      opb_q <= 32'h0;
    end else if (acc && paddr == 8'h00) begin
      opa_q <= pwdata;
    end else if (acc && paddr == 8'h04) begin
      opb_q <= pwdata;
    end
  end
  // ********
  // Properties
  // ********
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_pulse;
    branch_valid && branch_target == {opb_q[31:1], 1'b0} ##1 !branch_valid;
  endsequence
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_err_unmap: assert property (psel && penable && paddr > 8'h1C |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not flagged");
  a_logic_keep_cv: assert property (ctl && op <= 5'd3 |=> $stable(flags_nzcv[1:0]))
    else $error("logic op changed carry or overflow");
  a_and_nz: assert property (ctl && op == 5'd0 |=> flags_nzcv[3:2] == {anv[31], anv == 0})
    else $error("and flags wrong");
  a_test_nz: assert property (ctl && op == 5'd21 |=>
    flags_nzcv == {anv[31], anv == 0, $past(flags_nzcv[1:0])})
    else $error("bit test flags wrong");
  a_shift_keep_v: assert property (ctl && op >= 5'd4 && op <= 5'd7 |=> $stable(flags_nzcv[0]))
    else $error("shift changed overflow");
  a_cmp_flags: assert property (ctl && op == 5'd8 |=>
    flags_nzcv == {dif[31], dif == 0, opa_q >= opb_q, (opa_q[31] != opb_q[31]) && (dif[31] != opa_q[31])})
    else $error("compare flags wrong");
  a_cmn_flags: assert property (ctl && op == 5'd9 |=>
    flags_nzcv == {sum[31], sum[31:0] == 0, sum[32], (opa_q[31] == opb_q[31]) && (sum[31] != opa_q[31])})
    else $error("compare negative flags wrong");
  a_copy_noflag: assert property (ctl && (op == 5'd10 || op >= 5'd14 && op <= 5'd20) |=>
    $stable(flags_nzcv))
    else $error("flag change on a flagless op");
  a_mul_keep_cv: assert property (ctl && op == 5'd13 |=> $stable(flags_nzcv[1:0]))
    else $error("multiply changed carry or overflow");
  a_branch_pulse: assert property (br_req |=> s_pulse)
    else $error("branch pulse or target wrong");
  a_branch_cause: assert property (branch_valid |-> $past(br_req))
    else $error("branch without copy to counter");
endmodule

bind dpa_alu dpa_alu_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .flags_nzcv(flags_nzcv), .branch_valid(branch_valid), .branch_target(branch_target));

/* dpa_consts.svh */
/*
  Register offsets, field positions and reset values for the data processing ALU.
  Assumes a 32-bit APB bus with byte addresses and one aligned word per register.
*/
`ifndef DPA_CONSTS_SVH
`define DPA_CONSTS_SVH

`define DPA_ADDR_W       8
`define DPA_OFF_OPA      8'h00
`define DPA_OFF_OPB      8'h04
`define DPA_OFF_SHAMT    8'h08
`define DPA_OFF_CTRL     8'h0C
`define DPA_OFF_RESULT   8'h10
`define DPA_OFF_FLAGS    8'h14
`define DPA_OFF_TARGET   8'h18
`define DPA_OFF_STATUS   8'h1C

`define DPA_CTRL_OP_LSB  0
`define DPA_CTRL_OP_MSB  4
`define DPA_CTRL_IMM_SEL 5
`define DPA_CTRL_TO_PC   6
`define DPA_CTRL_IMM_LSB 8
`define DPA_CTRL_IMM_MSB 15

`define DPA_FLAG_N       31
`define DPA_FLAG_Z       30
`define DPA_FLAG_C       29
`define DPA_FLAG_V       28

`define DPA_STAT_DONE    0
`define DPA_STAT_BRANCH  1
`define DPA_STAT_REJECT  2

`define DPA_RST_WORD     32'h0000_0000
`define DPA_RST_FLAGS    4'h0

`define DPA_WORD_BITS    32
`define DPA_LSL_IMM_MAX  8'h1F
`define DPA_RSH_IMM_MIN  8'h01
`define DPA_RSH_IMM_MAX  8'h20

`endif

/* dpa_pkg.sv */
/*
  Types for the data processing ALU: operation codes and register selectors.
  Assumes the operation codes are numbered in the order listed, from zero.
*/
package dpa_pkg;

  typedef enum logic [4:0] {
    and_flags_op,
    or_flags_op,
    xor_flags_op,
    bit_clear_op,
    arith_right_shift_op,
    logical_left_shift_op,
    logical_right_shift_op,
    rotate_right_op,
    compare_op,
    compare_negative_op,
    copy_op,
    copy_flags_op,
    invert_copy_op,
    multiply_op,
    byte_swap_word_op,
    byte_swap_halves_op,
    swap_signext_half_op,
    sign_extend_byte_op,
    zero_extend_byte_op,
    sign_extend_half_op,
    zero_extend_half_op,
    bit_test_op
  } dpa_op_t;

  typedef enum logic [3:0] {
    sel_opa,
    sel_opb,
    sel_shamt,
    sel_ctrl,
    sel_result,
    sel_flags,
    sel_target,
    sel_status,
    sel_none
  } dpa_sel_t;

endpackage

/* dpa_regfile_model.sv */
/*
  Register file model standing in for the core's operand source.
  Assumes the bench reads operand values through its lookup function.
*/
module dpa_regfile_model;
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] regs [8] = '{32'h0F0F_F0F0, 32'h8000_0001, 32'h1234_5678, 32'h0000_00FF,
                            32'hFFFF_FFFF, 32'h7FFF_FFFF, 32'h0000_8180, 32'h0000_0000};
  // Only the low eight registers can be named as operands.
  function automatic logic [31:0] rd(input logic [2:0] n);
    return regs[n];
  endfunction
endmodule

/* tb_data_processing_alu.sv */
/*
  Self-checking bench for the data processing ALU over APB.
  Assumes the checker is bound to the design and operands come from the model.
*/
module tb_data_processing_alu;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] branch_target;
  logic [31:0] pr = 32'h0;
  logic [31:0] q;
  logic        e;
  logic        pready;
  logic        pslverr;
  logic        branch_valid;
  logic [3:0]  flags_nzcv;
  logic [7:0]  cnt [5] = '{8'h00, 8'h01, 8'h1F, 8'h20, 8'hFF};
  int          fail_count = 0;
  int          n_tests = 0;
  always #25 pclk = ~pclk;
  dpa_alu uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flags_nzcv(flags_nzcv), .branch_valid(branch_valid), .branch_target(branch_target));
  dpa_regfile_model rf ();
  // ********
  // Tasks
  // ********
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    n_tests++;
    if (y !== x) begin
      $display("MISMATCH %s expected %h seen %h", nm, x, y);
      fail_count++;
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      $display("MISMATCH pready expected 1 seen timeout");
      fail_count++;
      summarize();
    end else begin
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  function automatic logic [36:0] calc(input logic [4:0] op, input logic s, input logic [7:0] im,
                                       input logic [31:0] a, input logic [31:0] b0, input logic [7:0] sh);
    logic [31:0] b;
    logic [31:0] r;
    logic [31:0] d;
    logic [32:0] t;
    logic [3:0]  g;
    int          n;
    b = (s && (op == 5'd8 || op == 5'd11)) ? {24'h0, im} : b0;
    n = s ? im : sh;
    d = a - b;
    t = {1'b0, a} + b;
    r = pr;
    g = 4'hB;
    if (s && (op == 5'd7 || (op == 5'd5 && n > 31) || ((op == 5'd4 || op == 5'd6) && (n == 0 || n > 32))))
      return {1'b1, g, r};
    case (op)
      5'd0: r = a & b;
      5'd1: r = a | b;
      5'd2: r = a ^ b;
      5'd3: r = a & ~b;
      5'd4: {r, g[1]} = $signed({b, 1'b0}) >>> ((n > 32) ? 32 : n);
      5'd5: {g[1], r} = {1'b0, b} << ((n > 33) ? 33 : n);
      5'd6: {r, g[1]} = {b, 1'b0} >> ((n > 33) ? 33 : n);
      5'd7: r = (b >> (n % 32)) | (b << (32 - n % 32));
      5'd8: g = {d[31], d == 0, a >= b, (a[31] != b[31]) && (d[31] != a[31])};
      5'd9: g = {t[31], t[31:0] == 0, t[32], (a[31] == b[31]) && (t[31] != a[31])};
      5'd10, 5'd11: r = b;
      5'd12: r = ~b;
      5'd13: r = a * b;
      5'd14: r = {b[7:0], b[15:8], b[23:16], b[31:24]};
      5'd15: r = {b[23:16], b[31:24], b[7:0], b[15:8]};
      5'd16: r = {{16{b[7]}}, b[7:0], b[15:8]};
      5'd17: r = {{24{b[7]}}, b[7:0]};
      5'd18: r = {24'h0, b[7:0]};
      5'd19: r = {{16{b[15]}}, b[15:0]};
      5'd20: r = {16'h0, b[15:0]};
      default: g[3:2] = {a[31] & b[31], (a & b) == 0};
    endcase
    if (op >= 5'd4 && op <= 5'd7)
      g[1] = (n == 0) ? 1'b1 : ((op == 5'd7) ? r[31] : g[1]);
    if (op <= 5'd7 || (op >= 5'd11 && op <= 5'd13))
      g[3:2] = {r[31], r == 0};
    return {1'b0, g, r};
  endfunction
  // Loads operands, presets N=1 C=1 V=1, executes and reads back result, flags and status.
  task automatic run(input logic [4:0] op, input logic s, input logic [7:0] im,
                     input logic [2:0] ia, input logic [2:0] ib, input logic [7:0] sh);
    logic [36:0] x;
    x = calc(op, s, im, rf.rd(ia), rf.rd(ib), sh);
    xfer(1'b1, 8'h00, rf.rd(ia));
    xfer(1'b1, 8'h04, rf.rd(ib));
    xfer(1'b1, 8'h08, {24'h0, sh});
    xfer(1'b1, 8'h14, 32'hB000_0000);
    xfer(1'b1, 8'h0C, {16'h0, im, 2'b00, s, op});
    xfer(1'b0, 8'h10, 32'h0);
    chk("result", x[31:0], q);
    pr = x[31:0];
    xfer(1'b0, 8'h14, 32'h0);
    chk("flags", {28'h0, x[35:32]}, {28'h0, q[31:28]});
    chk("flag pins", {28'h0, x[35:32]}, {28'h0, flags_nzcv});
    xfer(1'b0, 8'h1C, 32'h0);
    chk("rejected", {31'h0, x[36]}, {31'h0, q[2]});
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk("reset flags", 32'h0, {28'h0, flags_nzcv});
    for (int i = 0; i < 4; i++) run(5'(i), 1'b0, 8'h00, 3'd1, 3'd4, 8'h00);
    run(5'd0, 1'b0, 8'h00, 3'd0, 3'd6, 8'h00);
    $display("logic test done");
    for (int i = 4; i < 8; i++) begin
      for (int j = 0; j < 5; j++) begin
        run(5'(i), 1'b1, cnt[j], 3'd0, 3'd1, 8'h00);
        run(5'(i), 1'b0, 8'h00, 3'd0, 3'd2, cnt[j]);
      end
    end
    $display("shift test done");
    run(5'd8, 1'b0, 8'h00, 3'd2, 3'd2, 8'h00);
    run(5'd8, 1'b0, 8'h00, 3'd5, 3'd4, 8'h00);
    run(5'd8, 1'b1, 8'hFF, 3'd7, 3'd0, 8'h00);
    run(5'd9, 1'b0, 8'h00, 3'd5, 3'd5, 8'h00);
    run(5'd9, 1'b0, 8'h00, 3'd4, 3'd1, 8'h00);
    run(5'd21, 1'b0, 8'h00, 3'd0, 3'd6, 8'h00);
    run(5'd21, 1'b0, 8'h00, 3'd1, 3'd7, 8'h00);
    $display("compare test done");
    run(5'd10, 1'b0, 8'h00, 3'd0, 3'd5, 8'h00);
    run(5'd11, 1'b0, 8'h00, 3'd0, 3'd1, 8'h00);
    run(5'd11, 1'b1, 8'hFF, 3'd0, 3'd0, 8'h00);
    run(5'd11, 1'b1, 8'h00, 3'd0, 3'd4, 8'h00);
    run(5'd12, 1'b0, 8'h00, 3'd0, 3'd4, 8'h00);
    run(5'd13, 1'b0, 8'h00, 3'd2, 3'd1, 8'h00);
    run(5'd13, 1'b0, 8'h00, 3'd4, 3'd4, 8'h00);
    for (int i = 14; i < 21; i++) begin
      run(5'(i), 1'b0, 8'h00, 3'd0, 3'd2, 8'h00);
      run(5'(i), 1'b0, 8'h00, 3'd0, 3'd6, 8'h00);
    end
    $display("move test done");
    xfer(1'b1, 8'h04, 32'h0000_1235);
    xfer(1'b1, 8'h0C, 32'h0000_004A);
    #1;
    chk("branch valid", 32'h1, {31'h0, branch_valid});
    chk("branch target", 32'h0000_1234, branch_target);
    xfer(1'b0, 8'h1C, 32'h0);
    chk("branch status", 32'h0000_0002, q);
    xfer(1'b0, 8'h10, 32'h0);
    chk("result after branch", pr, q);
    xfer(1'b1, 8'h10, 32'h5A5A_5A5A);
    xfer(1'b0, 8'h10, 32'h0);
    chk("read only result", pr, q);
    xfer(1'b0, 8'h20, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    $display("branch and map test done");
    summarize();
  end
endmodule
